//--- acc_math_defs.svh
// offsets, fields, reset values and counts of the math unit
`ifndef ACC_MATH_DEFS_SVH
`define ACC_MATH_DEFS_SVH

`define AMU_OFF_CMD 8'h00
`define AMU_OFF_OPERAND 8'h04
`define AMU_OFF_ACC 8'h08
`define AMU_OFF_ACC16 8'h0C
`define AMU_OFF_STACK 8'h10
`define AMU_OFF_STATUS 8'h14

`define AMU_CMD_OP_LSB 0
`define AMU_CMD_OP_MSB 2
`define AMU_CMD_MODE_LSB 4
`define AMU_CMD_MODE_MSB 5
`define AMU_CMD_ADDR_LSB 16
`define AMU_CMD_ADDR_MSB 31
`define AMU_STATUS_BUSY_BIT 16

`define AMU_RST_WORD 32'h0000_0000
`define AMU_DIV_STEPS 7'h40
`define AMU_REAL_BIAS_M1 10'h07E
`define AMU_REAL_EXP_MAX 10'h0FF

`endif

//--- amu_pkg.sv
// types shared by the accumulator math unit
package amu_pkg;

   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_DOUBLE_BCD_DIVIDE = 3'b001,
      OP_REAL_DIVIDE = 3'b010,
      OP_BCD_INCREMENT = 3'b011,
      OP_BCD_DECREMENT = 3'b100,
      OP_BINARY_ADD = 3'b101
   } op_e;

   typedef enum logic [1:0] {
      AM_DIRECT = 2'b00,
      AM_POINTER = 2'b01,
      AM_IMMEDIATE = 2'b10
   } amode_e;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PTR = 3'b001,
      ST_LO = 3'b010,
      ST_HI = 3'b011,
      ST_CALC = 3'b100,
      ST_DIV = 3'b101,
      ST_FIN = 3'b110,
      ST_WB = 3'b111
   } state_e;

   // bit 0 range, bit 9 32-bit carry
   typedef struct packed {
      logic carry32_flag;
      logic carry16_flag;
      logic format_error_flag;
      logic underflow_flag;
      logic signed_overflow_flag;
      logic float_validity_flag;
      logic pointer_error_flag;
      logic negative_flag;
      logic zero_flag;
      logic operand_range_flag;
   } flags_s;

   typedef struct packed {
      logic we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mem_cmd_s;

endpackage

//--- accumulator_math_unit.sv
// accumulator math unit: bcd and real divide, bcd inc/dec, binary add, ahb-lite registers
// Contract
// [RULE1] double divide: 32-bit bcd acc by two words
// [RULE2] sequencer never gives immediate divisor to double divide
// [RULE3] quotient to acc, remainder to stack top
// [RULE4] range flag when divisor unusable
// [RULE5] zero flag when result is zero
// [RULE6] negative flag when acc negative
// [RULE7] format flag on non-bcd operand
// [RULE8] real divide acc by immediate or two words
// [RULE9] pointer flag on invalid pointed location
// [RULE10] validity flag on invalid float result
// [RULE11] overflow flag on wrong result sign
// [RULE12] underflow flag on float underflow
// [RULE13] format flag on non-real operand
// [RULE14] increment adds bcd one, writes back
// [RULE15] decrement subtracts bcd one, writes back
// [RULE16] trigger inc/dec by one-shot pulse
// [RULE17] binary add of 16-bit operand to acc
// [RULE18] two's-complement add, full 32-bit sum
// [RULE19] narrow acc upper bits zero-filled first
// [RULE20] 16-bit carry flag from bit 15
// [RULE21] 32-bit carry flag from bit 31
// [RULE22] flags hold until next updating instruction
// [RULE23] affected flags always written, set or cleared
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "acc_math_defs.svh"
module accumulator_math_unit
   import amu_pkg::*;
#(
   parameter logic [16:0] MEM_WORDS = 17'h04000
) (
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   output logic o_mem_req,
   output mem_cmd_s o_mem_cmd,
   input wire logic i_mem_ack,
   input wire logic [15:0] i_mem_rdata,
   output logic o_busy,
   output logic o_done,
   output flags_s o_flags
);

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic is_bcd(input logic [31:0] v);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (v[4*i +: 4] > 4'h9) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   function automatic logic [31:0] bcd_to_bin(input logic [31:0] v);
      logic [31:0] r;
      r = 32'h0;
      for (int i = 7; i >= 0; i--) begin
         r = (r << 3) + (r << 1) + {28'h0, v[4*i +: 4]};
      end
      return r;
   endfunction

   // valid below 1e8 only
   function automatic logic [31:0] bin_to_bcd(input logic [31:0] v);
      logic [31:0] b;
      b = 32'h0;
      for (int i = 31; i >= 0; i--) begin
         for (int d = 0; d < 8; d++) begin
            if (b[4*d +: 4] > 4'h4) begin
               b[4*d +: 4] = b[4*d +: 4] + 4'h3;
            end
         end
         b = {b[30:0], v[i]};
      end
      return b;
   endfunction

   // wraps at 9999 and 0000
   function automatic logic [15:0] bcd_step(input logic [15:0] v, input logic dec);
      logic [15:0] r;
      logic cy;
      r = v;
      cy = 1'b1;
      for (int d = 0; d < 4; d++) begin
         if (cy) begin
            if (!dec && v[4*d +: 4] == 4'h9) begin
               r[4*d +: 4] = 4'h0;
            end else if (dec && v[4*d +: 4] == 4'h0) begin
               r[4*d +: 4] = 4'h9;
            end else begin
               r[4*d +: 4] = dec ? v[4*d +: 4] - 4'h1 : v[4*d +: 4] + 4'h1;
               cy = 1'b0;
            end
         end
      end
      return r;
   endfunction

   function automatic flags_s flag_mask(input op_e op);
      flags_s m;
      m = '0;
      m.pointer_error_flag = 1'b1;
      m.zero_flag = 1'b1;
      unique case (op)
         OP_DOUBLE_BCD_DIVIDE: begin
            m.operand_range_flag = 1'b1;
            m.negative_flag = 1'b1;
            m.format_error_flag = 1'b1;
         end
         OP_REAL_DIVIDE: begin
            m.negative_flag = 1'b1;
            m.float_validity_flag = 1'b1;
            m.signed_overflow_flag = 1'b1;
            m.underflow_flag = 1'b1;
            m.format_error_flag = 1'b1;
         end
         OP_BINARY_ADD: begin
            m.negative_flag = 1'b1;
            m.signed_overflow_flag = 1'b1;
            m.carry16_flag = 1'b1;
            m.carry32_flag = 1'b1;
         end
         default: begin
            m.format_error_flag = 1'b1;
         end
      endcase
      return m;
   endfunction

   function automatic logic op_legal(input logic [2:0] c);
      return c != 3'h0 && c < 3'h6;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   state_e state_q;
   op_e op_q;
   amode_e mode_q;
   logic [15:0] addr_q;
   logic [31:0] opnd_q;
   logic [31:0] operand_reg_q;
   logic [31:0] acc_q;
   logic acc_narrow_q;
   logic [31:0] stack_q;
   flags_s flags_q;
   flags_s res_q;
   logic [63:0] num_q;
   logic [31:0] den_q;
   logic [32:0] rem_q;
   logic [63:0] quo_q;
   logic [6:0] step_q;
   logic [9:0] exp_q;
   logic sgn_q;
   logic done_q;
   logic [15:0] wb_q;
   logic wr_pend_q;
   logic [7:0] wr_off_q;
   logic [31:0] hrdata_q;

   ////////////////////////////////////////////////////////////////////////////
   wire addr_phase = i_hsel & i_hready & i_htrans[1];
   wire high_zero = i_haddr[31:8] == 24'h0;
   wire [7:0] rd_off = i_haddr[7:0];
   wire [31:0] status_word = {15'h0, state_q != ST_IDLE, 6'h0, flags_q};
   wire [31:0] rd_mux =
      !high_zero ? 32'h0 :
      rd_off == `AMU_OFF_CMD ? {addr_q, 10'h0, mode_q, 1'b0, op_q} :
      rd_off == `AMU_OFF_OPERAND ? operand_reg_q :
      rd_off == `AMU_OFF_ACC ? acc_q :
      rd_off == `AMU_OFF_ACC16 ? {16'h0, acc_q[15:0]} :
      rd_off == `AMU_OFF_STACK ? stack_q :
      rd_off == `AMU_OFF_STATUS ? status_word : 32'h0;
   wire idle = state_q == ST_IDLE;
   wire [2:0] new_op = i_hwdata[`AMU_CMD_OP_MSB:`AMU_CMD_OP_LSB];
   wire [1:0] new_mode = i_hwdata[`AMU_CMD_MODE_MSB:`AMU_CMD_MODE_LSB];
   wire start = wr_pend_q & idle & (wr_off_q == `AMU_OFF_CMD) & op_legal(new_op);
   // immediate only for real divide and add [RULE2]
   wire start_imm = new_mode == AM_IMMEDIATE &&
      (new_op == OP_REAL_DIVIDE || new_op == OP_BINARY_ADD);
   wire two_words = op_q == OP_DOUBLE_BCD_DIVIDE || op_q == OP_REAL_DIVIDE;
   wire [16:0] ptr_end = {1'b0, i_mem_rdata} + {16'h0, two_words};
   wire ptr_bad = ptr_end >= MEM_WORDS; // [RULE9]
   wire sw_acc_wr = wr_pend_q & idle & (wr_off_q == `AMU_OFF_ACC);
   wire sw_acc16_wr = wr_pend_q & idle & (wr_off_q == `AMU_OFF_ACC16);

   // narrow acc adds low half only [RULE19]
   wire [31:0] acc_eff = acc_narrow_q ? {16'h0, acc_q[15:0]} : acc_q;
   wire [32:0] sum33 = {1'b0, acc_eff} + {17'h0, opnd_q[15:0]}; // [RULE17] [RULE18]
   wire [16:0] sum17 = {1'b0, acc_eff[15:0]} + {1'b0, opnd_q[15:0]};
   wire add_c16 = sum17[16]; // [RULE20]
   wire add_c32 = sum33[32]; // [RULE21]
   // zero-extended operand: only + to - is wrong
   wire add_ovf = ~acc_eff[31] & sum33[31]; // [RULE11]

   // real divide operands
   wire [7:0] exp_a = acc_q[30:23];
   wire [7:0] exp_b = opnd_q[30:23];
   wire real_bad = exp_a == 8'hFF || exp_b == 8'hFF; // [RULE13]
   wire real_sgn = acc_q[31] ^ opnd_q[31];
   wire [9:0] exp_fin = exp_q + {9'h0, quo_q[25]};
   wire [22:0] mant_fin = quo_q[25] ? quo_q[24:2] : quo_q[23:1];
   wire real_uflow = exp_fin[9] || exp_fin == 10'h0;
   wire real_oflow = !exp_fin[9] && exp_fin >= `AMU_REAL_EXP_MAX;

   // bcd operands
   wire bcd_ok = is_bcd(acc_q) & is_bcd(opnd_q); // [RULE7]
   wire mem_ok = is_bcd({16'h0, opnd_q[15:0]}); // [RULE7]
   wire [15:0] stepped = bcd_step(opnd_q[15:0], op_q == OP_BCD_DECREMENT);
   wire [31:0] bcd_quo = bin_to_bcd(quo_q[31:0]);

   // restoring step, both divides
   wire [32:0] rem_sh = {rem_q[31:0], num_q[63]};
   wire rem_ge = rem_sh >= {1'b0, den_q};
   wire [32:0] rem_nx = rem_ge ? rem_sh - {1'b0, den_q} : rem_sh;

   ////////////////////////////////////////////////////////////////////////////
   // zero-wait; read captured at address phase
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         wr_pend_q <= 1'b0;
         wr_off_q <= 8'h0;
         hrdata_q <= `AMU_RST_WORD;
      end else begin
         wr_pend_q <= addr_phase & i_hwrite & high_zero;
         wr_off_q <= rd_off;
         if (addr_phase & ~i_hwrite) begin
            hrdata_q <= rd_mux;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         operand_reg_q <= `AMU_RST_WORD;
      end else if (wr_pend_q && wr_off_q == `AMU_OFF_OPERAND) begin
         operand_reg_q <= i_hwdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         state_q <= ST_IDLE;
         op_q <= OP_NONE;
         mode_q <= AM_DIRECT;
         addr_q <= 16'h0;
         opnd_q <= `AMU_RST_WORD;
         acc_q <= `AMU_RST_WORD;
         acc_narrow_q <= 1'b0;
         stack_q <= `AMU_RST_WORD;
         flags_q <= '0;
         res_q <= '0;
         num_q <= 64'h0;
         den_q <= 32'h0;
         rem_q <= 33'h0;
         quo_q <= 64'h0;
         step_q <= 7'h0;
         exp_q <= 10'h0;
         sgn_q <= 1'b0;
         done_q <= 1'b0;
         wb_q <= 16'h0;
      end else begin
         done_q <= 1'b0;
         if (sw_acc_wr) begin
            acc_q <= i_hwdata;
            acc_narrow_q <= 1'b0;
         end
         if (sw_acc16_wr) begin
            acc_q <= {16'h0, i_hwdata[15:0]};
            acc_narrow_q <= 1'b1;
         end
         if (wr_pend_q && idle && wr_off_q == `AMU_OFF_STACK) begin
            stack_q <= i_hwdata;
         end
         unique case (state_q)
            ST_IDLE: begin
               if (start) begin
                  op_q <= op_e'(new_op);
                  mode_q <= start_imm ? AM_IMMEDIATE :
                     (new_mode == AM_POINTER ? AM_POINTER : AM_DIRECT);
                  addr_q <= i_hwdata[`AMU_CMD_ADDR_MSB:`AMU_CMD_ADDR_LSB];
                  res_q <= '0;
                  opnd_q <= operand_reg_q;
                  state_q <= start_imm ? ST_CALC :
                     (new_mode == AM_POINTER ? ST_PTR : ST_LO);
               end
            end
            ST_PTR: begin
               if (i_mem_ack) begin
                  if (ptr_bad) begin
                     res_q.pointer_error_flag <= 1'b1; // [RULE9]
                     state_q <= ST_FIN;
                     step_q <= 7'h0;
                  end else begin
                     addr_q <= i_mem_rdata;
                     state_q <= ST_LO;
                  end
               end
            end
            ST_LO: begin
               if (i_mem_ack) begin
                  opnd_q <= {16'h0, i_mem_rdata};
                  state_q <= two_words ? ST_HI : ST_CALC; // [RULE1] [RULE8]
               end
            end
            ST_HI: begin
               if (i_mem_ack) begin
                  opnd_q[31:16] <= i_mem_rdata;
                  state_q <= ST_CALC;
               end
            end
            ST_CALC: begin
               state_q <= ST_FIN;
               step_q <= 7'h0;
               unique case (op_q)
                  OP_BINARY_ADD: begin
                     acc_q <= sum33[31:0]; // [RULE18]
                     acc_narrow_q <= 1'b0;
                     res_q.zero_flag <= sum33[31:0] == 32'h0; // [RULE5]
                     res_q.negative_flag <= sum33[31]; // [RULE6]
                     res_q.carry16_flag <= add_c16; // [RULE20]
                     res_q.carry32_flag <= add_c32; // [RULE21]
                     res_q.signed_overflow_flag <= add_ovf; // [RULE11]
                  end
                  OP_BCD_INCREMENT, OP_BCD_DECREMENT: begin
                     if (!mem_ok) begin
                        res_q.format_error_flag <= 1'b1; // [RULE7]
                     end else begin
                        wb_q <= stepped; // [RULE14] [RULE15]
                        res_q.zero_flag <= stepped == 16'h0; // [RULE5]
                        state_q <= ST_WB;
                     end
                  end
                  OP_DOUBLE_BCD_DIVIDE: begin
                     if (!bcd_ok) begin
                        res_q.format_error_flag <= 1'b1; // [RULE7]
                     end else if (opnd_q == 32'h0) begin
                        res_q.operand_range_flag <= 1'b1; // [RULE4]
                     end else begin
                        num_q <= {32'h0, bcd_to_bin(acc_q)}; // [RULE1]
                        den_q <= bcd_to_bin(opnd_q);
                        rem_q <= 33'h0;
                        state_q <= ST_DIV;
                     end
                  end
                  default: begin
                     sgn_q <= real_sgn;
                     if (real_bad) begin
                        res_q.format_error_flag <= 1'b1; // [RULE13]
                     end else if (exp_b == 8'h00) begin
                        acc_q <= {real_sgn, 8'hFF, 23'h0};
                        res_q.float_validity_flag <= 1'b1; // [RULE10]
                        res_q.negative_flag <= real_sgn; // [RULE6]
                     end else if (exp_a == 8'h00) begin
                        acc_q <= {real_sgn, 31'h0};
                        res_q.zero_flag <= 1'b1; // [RULE5]
                     end else begin
                        // denormals flushed: hidden one set
                        num_q <= {15'h0, 1'b1, acc_q[22:0], 25'h0}; // [RULE8]
                        den_q <= {8'h0, 1'b1, opnd_q[22:0]};
                        rem_q <= 33'h0;
                        exp_q <= {2'b00, exp_a} - {2'b00, exp_b} + `AMU_REAL_BIAS_M1;
                        state_q <= ST_DIV;
                     end
                  end
               endcase
            end
            ST_DIV: begin
               rem_q <= rem_nx;
               num_q <= {num_q[62:0], 1'b0};
               quo_q <= {quo_q[62:0], rem_ge};
               step_q <= step_q + 7'h1;
               if (step_q == `AMU_DIV_STEPS - 7'h1) begin
                  state_q <= ST_FIN;
                  step_q <= 7'h1;
               end
            end
            ST_WB: begin
               if (i_mem_ack) begin
                  state_q <= ST_FIN;
                  step_q <= 7'h0;
               end
            end
            ST_FIN: begin
               state_q <= ST_IDLE;
               done_q <= 1'b1;
               // other ops' flags kept [RULE22]
               flags_q <= (flags_q & ~flag_mask(op_q)) | (res_q & flag_mask(op_q)); // [RULE23]
               if (step_q == 7'h1 && op_q == OP_DOUBLE_BCD_DIVIDE) begin
                  acc_q <= bcd_quo; // [RULE3]
                  stack_q <= bin_to_bcd(rem_q[31:0]); // [RULE3]
                  acc_narrow_q <= 1'b0;
                  flags_q.zero_flag <= bcd_quo == 32'h0; // [RULE5]
                  // bcd is unsigned: never negative
                  flags_q.negative_flag <= 1'b0; // [RULE6]
               end else if (step_q == 7'h1) begin
                  acc_narrow_q <= 1'b0;
                  flags_q.zero_flag <= real_uflow; // [RULE5]
                  flags_q.underflow_flag <= real_uflow; // [RULE12]
                  flags_q.float_validity_flag <= real_oflow; // [RULE10]
                  flags_q.negative_flag <= sgn_q & ~real_uflow; // [RULE6]
                  flags_q.signed_overflow_flag <= 1'b0; // [RULE11]
                  flags_q.format_error_flag <= 1'b0;
                  flags_q.pointer_error_flag <= 1'b0;
                  if (real_uflow) begin
                     acc_q <= {sgn_q, 31'h0}; // [RULE12]
                  end else if (real_oflow) begin
                     acc_q <= {sgn_q, 8'hFF, 23'h0}; // [RULE10]
                  end else begin
                     acc_q <= {sgn_q, exp_fin[7:0], mant_fin};
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // at most one write per command [RULE16]
   assign o_mem_req = state_q == ST_PTR || state_q == ST_LO ||
      state_q == ST_HI || state_q == ST_WB;
   assign o_mem_cmd.we = state_q == ST_WB;
   assign o_mem_cmd.addr = state_q == ST_HI ? addr_q + 16'h1 : addr_q;
   assign o_mem_cmd.wdata = wb_q;
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;
   assign o_hrdata = hrdata_q;
   assign o_busy = !idle;
   assign o_done = done_q;
   assign o_flags = flags_q;

endmodule

//--- amu_assertions.sv
// port checker of the math unit
`timescale 1ns/100ps
module amu_checker
   import amu_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic o_mem_req,
   input mem_cmd_s o_mem_cmd,
   input wire logic i_mem_ack,
   input wire logic o_busy,
   input wire logic o_done,
   input flags_s o_flags
);
   ////////////////////////////////////////////////////////////////////////////////
   wire logic cmd_hit = i_hsel && i_hready && i_htrans[1] && i_hwrite && i_haddr == 32'h0;
   wire logic wb = o_mem_req && o_mem_cmd.we;
   wire logic [15:0] wd = o_mem_cmd.wdata;
   logic cmd_dp_q;
   logic [2:0] op_q;
   logic [15:0] rd_addr_q;
   // op of the last cmd, to tie flags to it
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         cmd_dp_q <= 1'b0;
         op_q <= 3'h0;
         rd_addr_q <= 16'h0;
      end else begin
         cmd_dp_q <= cmd_hit;
         if (cmd_dp_q && !o_busy) op_q <= i_hwdata[2:0];
         if (o_mem_req && i_mem_ack && !o_mem_cmd.we) rd_addr_q <= o_mem_cmd.addr;
      end
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   ////////////////////////////////////////////////////////////////////////////////
   flags_hold_a: assert property (!o_done && !$past(i_srst) |-> $stable(o_flags))
      else $error("flags moved");
   done_pulse_a: assert property (o_done |=> !o_done)
      else $error("done too long");
   done_end_a: assert property (o_done |-> !o_busy && $past(o_busy))
      else $error("stray done");
   start_busy_a: assert property (cmd_dp_q && !o_busy && i_hwdata[2:0] inside {[3'h1:3'h5]}
      |=> o_busy)
      else $error("op not started");
   req_stands_a: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_cmd))
      else $error("request dropped");
   wb_incdec_a: assert property (wb |-> op_q inside {OP_BCD_INCREMENT, OP_BCD_DECREMENT})
      else $error("bad write-back op");
   wb_bcd_a: assert property (wb |-> wd[3:0] < 4'hA && wd[7:4] < 4'hA
      && wd[11:8] < 4'hA && wd[15:12] < 4'hA)
      else $error("write-back not bcd");
   wb_addr_a: assert property (wb |-> o_mem_cmd.addr == rd_addr_q)
      else $error("write-back address");
   range_div_a: assert property ($changed(o_flags.operand_range_flag) && !$past(i_srst)
      |-> op_q == OP_DOUBLE_BCD_DIVIDE)
      else $error("range flag moved");
   carry_add_a: assert property (($changed(o_flags.carry16_flag) || $changed(o_flags.carry32_flag))
      && !$past(i_srst) |-> op_q == OP_BINARY_ADD)
      else $error("carry flag moved");
endmodule

bind accumulator_math_unit amu_checker amu_checker_i (.*);

//--- mem_model.sv
// data memory model at the memory port
`timescale 1ns/100ps
module mem_model
   import amu_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_mem_req,
   input mem_cmd_s i_mem_cmd,
   input wire logic [1:0] i_lat,
   output logic o_mem_ack,
   output logic [15:0] o_mem_rdata
);
   logic [15:0] mem [0:63];
   logic [1:0] cnt_q;
   logic [15:0] last_q;
   // latency 0 acks in the request cycle
   assign o_mem_ack = i_mem_req && cnt_q == i_lat;
   // junk, not the last word, outside an ack
   assign o_mem_rdata = o_mem_ack ? mem[i_mem_cmd.addr[5:0]] : ~last_q;
   always @(posedge i_core_clk) begin
      if (i_srst || o_mem_ack) cnt_q <= 2'h0;
      else if (i_mem_req) cnt_q <= cnt_q + 2'h1;
      if (i_srst) last_q <= 16'h0;
      else if (o_mem_ack) last_q <= o_mem_rdata;
      if (o_mem_ack && i_mem_cmd.we) mem[i_mem_cmd.addr[5:0]] <= i_mem_cmd.wdata;
   end
endmodule

//--- testbench.sv
// self-checking bench of the accumulator math unit
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
   import amu_pkg::*;
   localparam logic [9:0] MD = 10'h08F, MR = 10'h0FE, MI = 10'h08A, MA = 10'h32E;
   logic i_core_clk, i_srst, i_hsel, i_hwrite, o_hreadyout, o_hresp, o_mem_req;
   logic i_mem_ack, o_busy, o_done, rd_dp;
   logic [31:0] i_haddr, i_hwdata, o_hrdata, seed, e, a;
   logic [1:0] i_htrans, lat;
   logic [2:0] i_hsize;
   logic [15:0] i_mem_rdata, b;
   logic [32:0] s;
   logic [9:0] ef;
   wire logic i_hready;
   mem_cmd_s o_mem_cmd;
   flags_s o_flags;
   logic [31:0] q[$];
   int n_mismatch, n_checks;
   assign i_hready = o_hreadyout;
   accumulator_math_unit #(.MEM_WORDS(17'h00040)) accumulator_math_unit_i (.*);
   mem_model mem_model_i (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_mem_req(o_mem_req),
      .i_mem_cmd(o_mem_cmd), .i_lat(lat), .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata));
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
      i_hsel <= 1'b1;
      i_htrans <= 2'h2;
      i_hwrite <= w;
      i_haddr <= {24'h0, ad};
      do @(posedge i_core_clk); while (i_hready !== 1'b1);
      i_hsel <= 1'b0;
      i_htrans <= 2'h0;
      i_hwdata <= d;
      do @(posedge i_core_clk); while (i_hready !== 1'b1);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] x);
      q.push_back(x);
      bus(1'b0, ad, 32'h0);
   endtask
   // bz: acc write while busy, dropped
   task automatic run(input logic [2:0] o, input logic [1:0] m, input logic [15:0] ad,
      input logic [9:0] mk, v, input logic bz = 1'b0);
      int k;
      ef = (ef & ~mk) | v;
      q.push_back({22'h0, ef});
      seed = xs(seed);
      lat <= seed[1:0];
      bus(1'b1, 8'h00, {ad, 10'h0, m, 1'b0, o});
      if (bz) bus(1'b1, 8'h08, 32'h9999_9999);
      k = 0;
      do begin @(negedge i_core_clk); k++; end while (o_done !== 1'b1 && k < 300);
      if (o_done !== 1'b1) n_mismatch++;
      @(posedge i_core_clk);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // oldest note vs read data or flags
   always @(posedge i_core_clk) begin
      if (rd_dp === 1'b1) begin
         e = q.pop_front();
         `CHK({o_hresp, o_hrdata}, {1'b0, e})
      end
      if (o_done === 1'b1) begin
         e = q.pop_front();
         `CHK({22'h0, o_flags}, e)
      end
      rd_dp <= i_hsel && i_htrans[1] && !i_hwrite && !i_srst;
   end
   initial begin
      #200000;
      n_mismatch++;
      complete_run();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {i_srst, i_hsel, i_htrans, i_hwrite, i_haddr, i_hwdata} = {5'h10, 64'h0};
      {i_hsize, lat, rd_dp, ef, n_mismatch, n_checks} = {3'h2, 13'h0, 64'h0};
      seed = 32'h18EF4329;
      {mem_model_i.mem[4], mem_model_i.mem[5], mem_model_i.mem[6]} = {16'h0100, 32'h0};
      {mem_model_i.mem[7], mem_model_i.mem[8], mem_model_i.mem[9]} = {32'h0, 16'h4000};
      {mem_model_i.mem[10], mem_model_i.mem[11], mem_model_i.mem[20]} = {48'h003F_0040_0999};
      {mem_model_i.mem[21], mem_model_i.mem[22], mem_model_i.mem[23]} = {48'h9999_00A0_0014};
      mem_model_i.mem[30] = 16'h0001;
      repeat (4) @(posedge i_core_clk);
      i_srst <= 1'b0;
      @(posedge i_core_clk);
      rd(8'h14, 32'h0);
      bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
      rd(8'h1C, 32'h0);
      bus(1'b1, 8'h08, 32'h1234_5678);
      run(3'h1, 2'h0, 16'h4, MD, 10'h000);
      rd(8'h08, 32'h0012_3456);
      rd(8'h10, 32'h0000_0078);
      bus(1'b1, 8'h08, 32'h5);
      run(3'h1, 2'h0, 16'h4, MD, 10'h002, 1'b1);
      rd(8'h08, 32'h0);
      rd(8'h10, 32'h5);
      run(3'h1, 2'h0, 16'h6, MD, 10'h001);
      run(3'h1, 2'h1, 16'hA, MD, 10'h008);
      bus(1'b1, 8'h08, 32'hAB);
      run(3'h1, 2'h0, 16'h4, MD, 10'h080);
      bus(1'b1, 8'h08, 32'h40C0_0000);
      bus(1'b1, 8'h04, 32'h4000_0000);
      run(3'h2, 2'h2, 16'h0, MR, 10'h000);
      rd(8'h08, 32'h4040_0000);
      bus(1'b1, 8'h08, 32'hC0C0_0000);
      run(3'h2, 2'h0, 16'h8, MR, 10'h004);
      rd(8'h08, 32'hC040_0000);
      bus(1'b1, 8'h08, 32'h40C0_0000);
      bus(1'b1, 8'h04, 32'h0);
      run(3'h2, 2'h2, 16'h0, MR, 10'h010);
      rd(8'h08, 32'h7F80_0000);
      bus(1'b1, 8'h08, 32'h0080_0000);
      bus(1'b1, 8'h04, 32'h4080_0000);
      run(3'h2, 2'h2, 16'h0, MR, 10'h042);
      bus(1'b1, 8'h08, 32'h7FC0_0000);
      run(3'h2, 2'h2, 16'h0, MR, 10'h080);
      run(3'h3, 2'h0, 16'd20, MI, 10'h000);
      `CHK(mem_model_i.mem[20], 16'h1000)
      run(3'h3, 2'h0, 16'd21, MI, 10'h002);
      `CHK(mem_model_i.mem[21], 16'h0000)
      run(3'h4, 2'h0, 16'd21, MI, 10'h000);
      `CHK(mem_model_i.mem[21], 16'h9999)
      run(3'h4, 2'h0, 16'd22, MI, 10'h080);
      `CHK(mem_model_i.mem[22], 16'h00A0)
      run(3'h3, 2'h1, 16'd23, MI, 10'h000);
      `CHK(mem_model_i.mem[20], 16'h1001)
      bus(1'b1, 8'h08, 32'h7FFF_FFFF);
      run(3'h5, 2'h0, 16'd30, MA, 10'h124);
      rd(8'h08, 32'h8000_0000);
      bus(1'b1, 8'h08, 32'hFFFF_FFFF);
      bus(1'b1, 8'h0C, 32'h1234);
      bus(1'b1, 8'h04, 32'hFFFF);
      run(3'h5, 2'h2, 16'h0, MA, 10'h100);
      rd(8'h08, 32'h0001_1233);
      run(3'h5, 2'h1, 16'hB, MA, 10'h008);
      for (int i = 0; i < 12; i++) begin
         seed = xs(seed);
         a = (i == 0) ? 32'hFFFF_FFFF : seed;
         seed = xs(seed);
         b = (i == 0) ? 16'h1 : seed[15:0];
         s = {1'b0, a} + {17'h0, b};
         bus(1'b1, 8'h08, a);
         bus(1'b1, 8'h04, {16'h0, b});
         run(3'h5, 2'h2, 16'h0, MA, {s[32], ({1'b0, a[15:0]} + {1'b0, b}) > 17'hFFFF,
            2'b0, !a[31] && s[31], 2'b0, s[31], s[31:0] == 32'h0, 1'b0});
         rd(8'h08, s[31:0]);
      end
      rd(8'h14, {22'h0, ef});
      @(posedge i_core_clk);
      complete_run();
   end
endmodule
